//--- core/egpr_regs.sv
// egress port second-channel and element self-description registers
// assumes accesses arrive from the base window decode, same clock
`timescale 1ns/1ps
`include "egpr_consts.svh"

// Function
// R1 - no-snoop-missing traffic on channel rejected
// R2 - channel enable read/write, resets zero
// R3 - software writes only non-zero channel ident
// R4 - arbitration select read/write, resets 100b
// R5 - seven-bit class map read/write, resets zero
// R6 - class zero map bit reads zero
// R7 - pending reads one while negotiating
// R8 - software checks pending clear at both ends
// R9 - arbitration capability reads 10h
// R10 - time-slot register read/write, resets 04050609h
// R11 - timing control resets zero, slot cycles
// R12 - 64-bit slot time register read/write
// R13 - port number reads 00h
// R14 - component ident write-once, resets 00h
// R15 - link entry count reads 02h
// R16 - element kind reads 1h
// R17 - write-once fields take first write only
// R18 - reserved bits read defaults, ignore writes
module egpr_regs
   import egpr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   // register access from the base window
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic [3:0]        reg_be_in,
   input  wire logic [31:0]       reg_wdata_in,
   output logic      [31:0]       reg_rdata_out,
   output logic                   reg_rvalid_out,
   output logic                   reg_unmapped_out,
   // link negotiation state of the second channel
   input  wire logic              chan_active_in,
   // transaction classification
   input  wire logic              tlp_valid_in,
   input  wire logic [2:0]        tlp_tc_in,
   input  wire logic              tlp_no_snoop_in,
   output logic                   tlp_to_second_out,
   output logic                   tlp_reject_ur_out,
   // channel configuration and isochronous slot tick
   output egpr_chan_cfg_t         cfg_out,
   output logic                   slot_tick_out
);

   egpr_access_t   acc;
   egpr_chan_cfg_t chan_cfg_r;
   logic           sticky_r;
   logic           pending_r;
   logic [31:0]    mts_r;
   logic [31:0]    itc_r;
   logic [63:0]    ist_r;
   logic [6:0]     cap_wo;
   logic [7:0]     comp_id;
   logic [31:0]    slot_cnt_r;
   logic           slot_tick_r;
   logic [31:0]    rdata_r;
   logic [31:0]    rdata_nxt;
   logic           hit_nxt;
   logic           rvalid_r;
   logic           unmapped_r;
   logic           to_second_r;
   logic           reject_r;
   logic           routed;

   assign acc.wr    = reg_wr_in;
   assign acc.rd    = reg_rd_in;
   assign acc.be    = reg_be_in;
   assign acc.wdata = reg_wdata_in;

   // dword select of an access
   function automatic logic sel(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      sel = (a[ADDR_W-1:2] == {{(ADDR_W-8){1'b0}}, off[7:2]});
   endfunction

   // merge write data under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = m;
   endfunction

   logic wr_cap;
   logic wr_ctl;
   logic wr_mts;
   logic wr_itc;
   logic wr_ist_lo;
   logic wr_ist_hi;
   logic wr_esd;

   assign wr_cap    = acc.wr && sel(reg_addr_in, `EGPR_OFF_CAP);
   assign wr_ctl    = acc.wr && sel(reg_addr_in, `EGPR_OFF_CTL);
   assign wr_mts    = acc.wr && sel(reg_addr_in, `EGPR_OFF_MTS);
   assign wr_itc    = acc.wr && sel(reg_addr_in, `EGPR_OFF_ITC);
   assign wr_ist_lo = acc.wr && sel(reg_addr_in, `EGPR_OFF_IST_LO);
   assign wr_ist_hi = acc.wr && sel(reg_addr_in, `EGPR_OFF_IST_HI);
   assign wr_esd    = acc.wr && sel(reg_addr_in, `EGPR_OFF_ESD);

   // write-once capability bits 22:16
   egpr_wonce #(
      .WIDTH (7),
      .RST   (7'h00)
   ) u_cap_wo (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .wr_in     (wr_cap && acc.be[2]),
      .wdata_in  (acc.wdata[`EGPR_CAP_WO_HI:`EGPR_CAP_WO_LO]),
      .value_out (cap_wo)
   ); // R17

   // write-once component ident
   egpr_wonce #(
      .WIDTH (8),
      .RST   (`EGPR_ESD_CID_RST)
   ) u_comp_id (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .wr_in     (wr_esd && acc.be[2]),
      .wdata_in  (acc.wdata[23:16]),
      .value_out (comp_id)
   ); // R14

   // second channel control
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         chan_cfg_r.en        <= 1'(`EGPR_CTL_RST >> `EGPR_CTL_EN_BIT);
         chan_cfg_r.ident     <= `EGPR_ID_RST;
         chan_cfg_r.arb_sel   <= `EGPR_PAS_RST;
         chan_cfg_r.class_map <= {`EGPR_MAP_RST, 1'b0};
         sticky_r             <= 1'b0;
      end else if (wr_ctl) begin
         if (acc.be[3]) begin
            chan_cfg_r.en <= acc.wdata[`EGPR_CTL_EN_BIT]; // R2
         end
         if (acc.be[3]) begin
            chan_cfg_r.ident <=
               acc.wdata[`EGPR_CTL_ID_HI:`EGPR_CTL_ID_LO]; // R3
         end
         if (acc.be[2]) begin
            chan_cfg_r.arb_sel <=
               acc.wdata[`EGPR_CTL_PAS_HI:`EGPR_CTL_PAS_LO]; // R4
            sticky_r <= acc.wdata[`EGPR_CTL_STK_BIT];
         end
         if (acc.be[0]) begin
            chan_cfg_r.class_map <=
               {acc.wdata[`EGPR_CTL_MAP_HI:`EGPR_CTL_MAP_LO], 1'b0}; // R5 R6
         end
      end
   end

   // negotiation pending while enable and link state disagree
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pending_r <= 1'b0;
      end else begin
         pending_r <= chan_cfg_r.en != chan_active_in; // R7
      end
   end

   // time-slot and timing registers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         mts_r <= `EGPR_MTS_RST; // R10
      end else if (wr_mts) begin
         mts_r <= merge(mts_r, acc.wdata, acc.be); // R10
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         itc_r <= `EGPR_ITC_RST; // R11
      end else if (wr_itc) begin
         itc_r <= merge(itc_r, acc.wdata, acc.be);
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ist_r <= `EGPR_IST_RST;
      end else if (wr_ist_lo) begin
         ist_r[31:0] <= merge(ist_r[31:0], acc.wdata, acc.be); // R12
      end else if (wr_ist_hi) begin
         ist_r[63:32] <= merge(ist_r[63:32], acc.wdata, acc.be); // R12
      end
   end

   // slot tick every itc_r cycles, idle while zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         slot_cnt_r  <= 32'h00000000;
         slot_tick_r <= 1'b0;
      end else if (itc_r == 32'h00000000) begin
         slot_cnt_r  <= 32'h00000000;
         slot_tick_r <= 1'b0;
      end else if (slot_cnt_r >= itc_r - 32'h00000001) begin
         slot_cnt_r  <= 32'h00000000;
         slot_tick_r <= 1'b1; // R11
      end else begin
         slot_cnt_r  <= slot_cnt_r + 32'h00000001;
         slot_tick_r <= 1'b0;
      end
   end

   // read data mux
   always_comb begin
      rdata_nxt = 32'h00000000;
      hit_nxt   = 1'b1;
      if (sel(reg_addr_in, `EGPR_OFF_CAP)) begin
         rdata_nxt = {`EGPR_CAP_TOP, 1'b0, cap_wo,
                      1'b1, 7'h00, `EGPR_CAP_PAC}; // R1 R9 R18
      end else if (sel(reg_addr_in, `EGPR_OFF_CTL)) begin
         rdata_nxt = {chan_cfg_r.en, 4'h0, chan_cfg_r.ident,
                      4'h0, chan_cfg_r.arb_sel, sticky_r, 8'h00,
                      chan_cfg_r.class_map[7:1], 1'b0}; // R6 R18
      end else if (sel(reg_addr_in, `EGPR_OFF_STS_DW)) begin
         rdata_nxt = {14'h0000, pending_r, 1'b0, 16'h0000}; // R7
      end else if (sel(reg_addr_in, `EGPR_OFF_MTS)) begin
         rdata_nxt = mts_r;
      end else if (sel(reg_addr_in, `EGPR_OFF_ITC)) begin
         rdata_nxt = itc_r;
      end else if (sel(reg_addr_in, `EGPR_OFF_IST_LO)) begin
         rdata_nxt = ist_r[31:0];
      end else if (sel(reg_addr_in, `EGPR_OFF_IST_HI)) begin
         rdata_nxt = ist_r[63:32];
      end else if (sel(reg_addr_in, `EGPR_OFF_ESD)) begin
         rdata_nxt = {`EGPR_ESD_PORT, comp_id, `EGPR_ESD_NLE,
                      4'h0, `EGPR_ESD_KIND}; // R13 R15 R16
      end else begin
         hit_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_r    <= 32'h00000000;
         rvalid_r   <= 1'b0;
         unmapped_r <= 1'b0;
      end else begin
         rdata_r    <= acc.rd ? rdata_nxt : 32'h00000000;
         rvalid_r   <= acc.rd;
         unmapped_r <= (acc.rd || acc.wr) && !hit_nxt; // R18
      end
   end

   // traffic class routing and snoop rejection
   assign routed = chan_cfg_r.en && chan_cfg_r.class_map[tlp_tc_in];

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         to_second_r <= 1'b0;
         reject_r    <= 1'b0;
      end else begin
         to_second_r <= tlp_valid_in && routed; // R5 R6
         reject_r    <= tlp_valid_in && routed && !tlp_no_snoop_in; // R1
      end
   end

   assign reg_rdata_out     = rdata_r;
   assign reg_rvalid_out    = rvalid_r;
   assign reg_unmapped_out  = unmapped_r;
   assign tlp_to_second_out = to_second_r;
   assign tlp_reject_ur_out = reject_r;
   assign cfg_out           = chan_cfg_r;
   assign slot_tick_out     = slot_tick_r;

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   sequence s_ctl_wr_hi;
      wr_ctl && acc.be[3];
   endsequence

   sequence s_rd(logic [7:0] off);
      acc.rd && sel(reg_addr_in, off);
   endsequence

   AST_REJECT_UR: assert property ( // R1
      (tlp_valid_in && routed && !tlp_no_snoop_in) |=> tlp_reject_ur_out)
      else $error("snoop transaction on second channel not rejected");

   AST_NO_REJECT_SNOOPLESS: assert property ( // R1
      (tlp_valid_in && tlp_no_snoop_in) |=> !tlp_reject_ur_out)
      else $error("no-snoop transaction rejected");

   AST_ENABLE_WRITE_READ: assert property ( // R2
      (s_ctl_wr_hi ##1 !acc.wr ##1 s_rd(`EGPR_OFF_CTL))
      |=> reg_rdata_out[`EGPR_CTL_EN_BIT] == $past(acc.wdata[31], 3))
      else $error("enable read back differs from write");

   AST_PAS_WRITE: assert property ( // R4
      (wr_ctl && acc.be[2]) |=> cfg_out.arb_sel == $past(acc.wdata[19:17]))
      else $error("arbitration select not updated");

   AST_TC0_NEVER: assert property ( // R6
      (tlp_valid_in && tlp_tc_in == 3'h0) |=> !tlp_to_second_out)
      else $error("class zero routed to second channel");

   AST_MAP_ROUTE: assert property ( // R5
      (tlp_valid_in && chan_cfg_r.en && tlp_tc_in != 3'h0
       && chan_cfg_r.class_map[tlp_tc_in]) |=> tlp_to_second_out)
      else $error("mapped class not routed");

   AST_PENDING: assert property ( // R7
      (chan_cfg_r.en != chan_active_in) ##1 s_rd(`EGPR_OFF_STS_DW)
      |=> reg_rdata_out[`EGPR_STS_SHIFT + `EGPR_STS_NP_BIT])
      else $error("pending not shown during negotiation");

   AST_CAP_READ: assert property ( // R9
      s_rd(`EGPR_OFF_CAP) |=> reg_rdata_out[7:0] == `EGPR_CAP_PAC
      && reg_rdata_out[`EGPR_CAP_SNP_BIT] && reg_rdata_out[31:24] == 8'h10)
      else $error("capability read value wrong");

   AST_ESD_READ: assert property ( // R13
      s_rd(`EGPR_OFF_ESD) |=> reg_rdata_out[31:24] == `EGPR_ESD_PORT
      && reg_rdata_out[15:8] == `EGPR_ESD_NLE
      && reg_rdata_out[7:0] == {4'h0, `EGPR_ESD_KIND})
      else $error("self-description read value wrong");

   AST_SLOT_TICK: assert property ( // R11
      (itc_r == 32'h00000001) [*3] |-> slot_tick_out)
      else $error("slot tick missing with one-cycle slot");

   AST_UNMAPPED: assert property ( // R18
      (acc.rd && !hit_nxt) |=> reg_rdata_out == 32'h00000000
      && reg_unmapped_out)
      else $error("unmapped read not answered with zero");

endmodule

//--- core/egpr_wonce.sv
// write-once field: takes only the first write after reset
// assumes the caller decodes the register and byte lane
`timescale 1ns/1ps
module egpr_wonce #(
   parameter int             WIDTH = 8,
   parameter logic [WIDTH-1:0] RST = '0
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // write side
   input  wire logic             wr_in,
   input  wire logic [WIDTH-1:0] wdata_in,
   // field value
   output logic      [WIDTH-1:0] value_out
);

   logic             written_r;
   logic [WIDTH-1:0] value_r;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         written_r <= 1'b0;
      end else if (wr_in) begin
         written_r <= 1'b1; // R17
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         value_r <= RST;
      end else if (wr_in && !written_r) begin
         value_r <= wdata_in; // R17
      end
   end

   assign value_out = value_r;

   AST_WONCE_LOCK: assert property ( // R17
      @(posedge clk_in) disable iff (reset_in)
      (written_r && wr_in) |=> $stable(value_r))
      else $error("write-once field changed after first write");

endmodule

//--- pkg/egpr_consts.svh
// egress port second-channel register bank: offsets, fields, resets
// assumes byte offsets within the egress port base window
`ifndef EGPR_CONSTS_SVH
`define EGPR_CONSTS_SVH

// byte offsets
`define EGPR_OFF_CAP      8'h1C
`define EGPR_OFF_CTL      8'h20
`define EGPR_OFF_STS      8'h26
`define EGPR_OFF_STS_DW   8'h24
`define EGPR_OFF_MTS      8'h28
`define EGPR_OFF_ITC      8'h2C
`define EGPR_OFF_IST_LO   8'h38
`define EGPR_OFF_IST_HI   8'h3C
`define EGPR_OFF_ESD      8'h44

// reset values
`define EGPR_CAP_RST      32'h10008010
`define EGPR_CTL_RST      32'h01080000
`define EGPR_STS_RST      16'h0000
`define EGPR_MTS_RST      32'h04050609
`define EGPR_ITC_RST      32'h00000000
`define EGPR_IST_RST      64'h0000000000000000
`define EGPR_ESD_RST      32'h00000201

// capability fields
`define EGPR_CAP_TOP      8'h10
`define EGPR_CAP_SNP_BIT  15
`define EGPR_CAP_PAC      8'h10
`define EGPR_CAP_WO_HI    22
`define EGPR_CAP_WO_LO    16

// control fields
`define EGPR_CTL_EN_BIT   31
`define EGPR_CTL_ID_HI    26
`define EGPR_CTL_ID_LO    24
`define EGPR_CTL_PAS_HI   19
`define EGPR_CTL_PAS_LO   17
`define EGPR_CTL_STK_BIT  16
`define EGPR_CTL_MAP_HI   7
`define EGPR_CTL_MAP_LO   1
`define EGPR_ID_RST       3'h1
`define EGPR_PAS_RST      3'h4
`define EGPR_MAP_RST      7'h00

// status fields (status sits in the upper half of its dword)
`define EGPR_STS_NP_BIT   1
`define EGPR_STS_SHIFT    16

// self-description fields
`define EGPR_ESD_PORT     8'h00
`define EGPR_ESD_CID_RST  8'h00
`define EGPR_ESD_NLE      8'h02
`define EGPR_ESD_KIND     4'h1

`endif

//--- pkg/egpr_pkg.sv
// egress port second-channel register bank: shared types
// assumes egpr_consts.svh for numeric values
package egpr_pkg;

   // configuration of the second channel as seen by the datapath
   typedef struct packed {
      logic       en;
      logic [2:0] ident;
      logic [2:0] arb_sel;
      logic [7:0] class_map;
   } egpr_chan_cfg_t;

   // one register access from the base window
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  be;
      logic [31:0] wdata;
   } egpr_access_t;

endpackage

//--- tb/egpr_tb.sv
// bench for the second-channel register bank, random plus corner cases
// assumes egpr_regs alone, every port driven from here
`timescale 1ns/1ps
`include "egpr_consts.svh"
module tb
   import egpr_pkg::*;
;
   logic           clk_in = 1'b0;
   logic           reset_in = 1'b1;
   logic [11:0]    addr = 12'h000;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic [3:0]     be = 4'h0;
   logic [31:0]    wdata = 32'h00000000;
   logic           active = 1'b0;
   logic           tv = 1'b0;
   logic [2:0]     tc = 3'h0;
   logic           ns = 1'b0;
   logic [31:0]    rdata;
   logic           rvalid;
   logic           unmapped;
   logic           to2;
   logic           rej;
   logic           tick;
   egpr_chan_cfg_t cfg;
   int             bad_count = 0;
   int             n_compared = 0;
   logic [31:0]    ctl;
   logic [31:0]    v;
   logic [31:0]    d;
   logic [3:0]     b;
   logic           u;
   logic           rt;
   int             i;
   int             j;
   int             k;
   int             n;

   localparam logic [7:0] OFFS [8] = '{`EGPR_OFF_CAP, `EGPR_OFF_CTL,
      `EGPR_OFF_STS_DW, `EGPR_OFF_MTS, `EGPR_OFF_ITC, `EGPR_OFF_IST_LO,
      `EGPR_OFF_IST_HI, `EGPR_OFF_ESD};
   localparam logic [31:0] RSTS [8] = '{`EGPR_CAP_RST, `EGPR_CTL_RST,
      32'h00000000, `EGPR_MTS_RST, `EGPR_ITC_RST, 32'h00000000,
      32'h00000000, `EGPR_ESD_RST};

   egpr_regs u_egpr_regs (
      .clk_in            (clk_in),
      .reset_in          (reset_in),
      .reg_addr_in       (addr),
      .reg_wr_in         (wr),
      .reg_rd_in         (rd),
      .reg_be_in         (be),
      .reg_wdata_in      (wdata),
      .reg_rdata_out     (rdata),
      .reg_rvalid_out    (rvalid),
      .reg_unmapped_out  (unmapped),
      .chan_active_in    (active),
      .tlp_valid_in      (tv),
      .tlp_tc_in         (tc),
      .tlp_no_snoop_in   (ns),
      .tlp_to_second_out (to2),
      .tlp_reject_ur_out (rej),
      .cfg_out           (cfg),
      .slot_tick_out     (tick)
   );

   always #12.5 clk_in = ~clk_in;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask

   task conclude;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task wrr(input logic [7:0] a, input logic [3:0] m, input logic [31:0] x);
      @(posedge clk_in);
      addr  <= {4'h0, a};
      be    <= m;
      wdata <= x;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask

   task rdr(input logic [7:0] a, output logic [31:0] x, output logic um);
      @(posedge clk_in);
      addr <= {4'h0, a};
      rd   <= 1'b1;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1;
      x  = rdata;
      um = unmapped;
   endtask

   task do_reset;
      @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
   endtask

   task reset_check;
      for (int q = 0; q < 8; q++) begin
         rdr(OFFS[q], v, u);
         chk(v, RSTS[q]);
         chk({30'h0, rvalid, u}, 32'h00000002);
      end
   endtask

   // model of control writes, lane gated
   function automatic logic [31:0] ctl_next(input logic [31:0] o,
      input logic [31:0] x, input logic [3:0] m);
      logic [31:0] r;
      r = o;
      if (m[3]) begin
         r[31]    = x[31];
         r[26:24] = x[26:24];
      end
      if (m[2]) r[19:16] = x[19:16];
      if (m[0]) r[7:1] = x[7:1];
      return r;
   endfunction

   initial begin
      #200000;
      bad_count++;
      conclude;
   end

   initial begin
      v = $urandom(32'h3E73);
      do_reset;
      reset_check;
      // reserved hole in the map
      rdr(8'h30, v, u);
      chk(v, 32'h00000000);
      chk({31'h0, u}, 32'h00000001);
      // write-once capability field and component ident
      wrr(`EGPR_OFF_CAP, 4'hB, 32'hFFFFFFFF);
      rdr(`EGPR_OFF_CAP, v, u);
      chk(v, `EGPR_CAP_RST);
      d = $urandom;
      for (i = 0; i < 2; i++) begin
         wrr(`EGPR_OFF_CAP, 4'hF, i ? ~d : d);
         rdr(`EGPR_OFF_CAP, v, u);
         chk(v, `EGPR_CAP_RST | {9'h0, d[22:16], 16'h0});
         wrr(`EGPR_OFF_ESD, 4'hF, i ? ~d : d);
         rdr(`EGPR_OFF_ESD, v, u);
         chk(v, `EGPR_ESD_RST | {8'h0, d[23:16], 16'h0});
      end
      // plain read/write registers
      for (k = 3; k < 7; k++) begin
         d = $urandom;
         wrr(OFFS[k], 4'hF, d);
         rdr(OFFS[k], v, u);
         chk(v, d);
      end
      // control rounds, pending status, traffic
      ctl = `EGPR_CTL_RST;
      for (i = 0; i < 8; i++) begin
         d = $urandom;
         b = (i < 2) ? 4'hF : 4'($urandom);
         d[31] = ~i[0];
         if (d[26:24] == 3'h0) d[24] = 1'b1;
         ctl = ctl_next(ctl, d, b);
         wrr(`EGPR_OFF_CTL, b, d);
         #1;
         chk({17'h0, cfg}, {17'h0, ctl[31], ctl[26:24], ctl[19:17],
              ctl[7:1], 1'b0});
         rdr(`EGPR_OFF_CTL, v, u);
         chk(v, ctl);
         for (j = 0; j < 2; j++) begin
            @(posedge clk_in);
            active <= j ? ctl[31] : ~ctl[31];
            @(posedge clk_in);
            rdr(`EGPR_OFF_STS_DW, v, u);
            chk(v, {14'h0, ~j[0], 17'h0});
         end
         for (k = 0; k < 16; k++) begin
            @(posedge clk_in);
            tv <= 1'b1;
            tc <= k[2:0];
            ns <= k[3];
            rt = ctl[31] & ctl[k[2:0]] & (k[2:0] != 3'h0);
            @(posedge clk_in);
            tv <= 1'b0;
            #1;
            chk({30'h0, to2, rej}, {30'h0, rt, rt & ~k[3]});
         end
      end
      // slot tick period
      wrr(`EGPR_OFF_ITC, 4'hF, 32'h00000005);
      for (i = 0; i < 2; i++) begin
         n = 0;
         do begin
            @(posedge clk_in);
            #1;
            n++;
         end while (tick !== 1'b1 && n < 40);
      end
      chk(n, 5);
      // one host clock per slot ticks every cycle
      wrr(`EGPR_OFF_ITC, 4'hF, 32'h00000001);
      repeat (3) @(posedge clk_in);
      #1;
      chk({31'h0, tick}, 32'h00000001);
      wrr(`EGPR_OFF_ITC, 4'hF, 32'h00000000);
      repeat (2) @(posedge clk_in);
      n = 0;
      repeat (20) begin
         @(posedge clk_in);
         #1;
         if (tick === 1'b1) n++;
      end
      chk(n, 0);
      // reset in mid-run
      @(posedge clk_in);
      active <= 1'b0;
      do_reset;
      reset_check;
      conclude;
   end
endmodule
